// ### synth_config_pkg.sv
`default_nettype none
package synth_config_pkg;

  // access lengths, counted in serial clocks
  localparam logic [4:0] CFG_ACCESS_BITS  = 5'h08;
  localparam logic [4:0] REF_ACCESS_BITS  = 5'h10;
  localparam logic [4:0] DIV_ACCESS_BITS  = 5'h18;
  localparam logic [4:0] INIT_GROUP_BITS  = 5'h05;
  localparam logic [4:0] BIT_COUNT_MAX    = 5'h1F;
  localparam logic [4:0] BIT_COUNT_FIRST  = 5'h01;
  localparam logic [1:0] INIT_GROUPS_LAST = 2'h2;
  localparam int         SHIFT_W          = 24;

  // divider register fields
  localparam int         OUTA_SEL_HI      = 23;
  localparam int         OUTA_SEL_LO      = 22;
  localparam logic [1:0] OUTA_DATA_OUT    = 2'h0;
  localparam logic [1:0] OUTA_REF_PULSE   = 2'h1;
  localparam logic [1:0] OUTA_VCO_PULSE   = 2'h2;
  localparam logic [1:0] OUTA_PORT        = 2'h3;
  localparam logic [23:0] DIV_RESET       = 24'h000000;

  // reference register fields
  localparam int         REF_MODE_HI      = 15;
  localparam int         REF_MODE_LO      = 13;
  localparam int         REF_CNT_W        = 13;
  localparam logic [2:0] REF_STATIC_LOW   = 3'h0;
  localparam logic [2:0] REF_MODE_RESET   = 3'h4;
  localparam logic [12:0] REF_CNT_RESET   = 13'h0000;

  // charge-pump current in percent of full scale
  localparam logic [6:0] PCT_25  = 7'h19;
  localparam logic [6:0] PCT_50  = 7'h32;
  localparam logic [6:0] PCT_70  = 7'h46;
  localparam logic [6:0] PCT_75  = 7'h4B;
  localparam logic [6:0] PCT_80  = 7'h50;
  localparam logic [6:0] PCT_90  = 7'h5A;
  localparam logic [6:0] PCT_100 = 7'h64;

  typedef struct packed {
    logic       detector_sense_invert;
    logic       detector_choice;
    logic       lock_output_allow;
    logic       low_power_hold;
    logic [1:0] pump_current_select;
    logic       port_bit;
    logic       out_b_release;
  } config_s;

  localparam config_s CFG_RESET = 8'h00;

  function automatic logic [6:0] pump_pct(input logic [1:0] sel, input logic coarse);
    logic [6:0] fine_pct;
    logic [6:0] coarse_pct;
    fine_pct   = (sel == 2'h0) ? PCT_70 : (sel == 2'h1) ? PCT_80 : (sel == 2'h2) ? PCT_90 : PCT_100;
    coarse_pct = (sel == 2'h0) ? PCT_25 : (sel == 2'h1) ? PCT_50 : (sel == 2'h2) ? PCT_75 : PCT_100;
    return coarse ? coarse_pct : fine_pct;
  endfunction : pump_pct

endpackage : synth_config_pkg
`default_nettype wire

// ### synth_config_control.sv
`default_nettype none
// Summary of operation
// - eight-clock access stores the configuration byte, other registers untouched
// - bit 7 inverts single-ended sense and swaps the two pulse outputs
// - bit 6 picks single-ended detector, otherwise the double-ended pair
// - bit 5 lets the lock indicator run, else held low
// - bit 4 standby: float single-ended, pair high, counters stopped, bias off
// - standby lock indicator follows bit 5: low or static high
// - divider, reference and configuration contents kept through standby
// - standby with static-low reference mode cuts feedback resistor and input
// - recovery step one: counters and bias back, detectors still blocked
// - step two on first vco pulse: jam reference counter, start detectors
// - bit 1 low, no port: current 70, 80, 90, 100 percent
// - bit 1 high, no port: current 25, 50, 75, 100 percent
// - both current bits high give full current
// - output A as port follows bit 1
// - output A as port forces the ten-percent step table
// - bit 0 releases open-drain output B, low drives it low
// - standby leaves the port level on output A unchanged
// - output A starts as serial data out after reset
// - 24-clock load stores divider and copies first reference buffer to second
module synth_config_control (
  input  wire logic                serial_clk,
  input  wire logic                serial_data,
  input  wire logic                latch_strobe,
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic                ref_divided_pulse,
  input  wire logic                vco_divided_pulse,
  output var  logic                charge_pump_source,
  output var  logic                charge_pump_sink,
  output var  logic                charge_pump_out_oe_n,
  output var  logic [6:0]          pump_current_pct,
  output var  logic                phase_r_out,
  output var  logic                phase_v_out,
  output var  logic                lock_indicator,
  output var  logic                output_a,
  output var  logic                output_b_out,
  output var  logic                output_b_oe_n,
  output var  logic                ref_feedback_on,
  output var  logic                ref_input_on,
  output var  logic [2:0]          ref_mode,
  output var  logic                bias_on,
  output var  logic                counters_run,
  output var  logic                counter_jam,
  output var  logic [23:0]         divider_value,
  output var  logic [12:0]         ref_count_value
);

  typedef enum logic [2:0] {
    ST_RUN     = 3'h1,
    ST_HOLD    = 3'h2,
    ST_WAIT_V  = 3'h4
  } power_e;

  // link domain: shifter and clock counter
  logic [synth_config_pkg::SHIFT_W-1:0] shift_word;
  logic [4:0]                           bit_count;
  logic                                 frame_fresh;
  wire                                  fresh_set = rst | latch_strobe;

  // frame_fresh is preset by the strobe itself, so no link edge is needed after a frame
  always_ff @(posedge serial_clk or posedge fresh_set) begin
    if (fresh_set) begin
      frame_fresh <= 1'b1;
    end else begin
      frame_fresh <= 1'b0;
    end
  end

  always_ff @(posedge serial_clk or posedge rst) begin
    if (rst) begin
      shift_word <= '0;
      bit_count  <= '0;
    end else begin
      shift_word <= {shift_word[synth_config_pkg::SHIFT_W-2:0], serial_data};
      if (frame_fresh) begin
        bit_count <= synth_config_pkg::BIT_COUNT_FIRST;
      end else if (bit_count != synth_config_pkg::BIT_COUNT_MAX) begin
        bit_count <= bit_count + 5'h01;
      end
    end
  end

  // system domain: strobe synchroniser, three stages
  logic strobe_s1;
  logic strobe_s2;
  logic strobe_s3;
  logic strobe_stable;
  logic dout_s1;
  logic dout_s2;
  logic dout_s3;
  logic dout_stable;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      strobe_s1 <= 1'b0;
      strobe_s2 <= 1'b0;
      strobe_s3 <= 1'b0;
      dout_s1   <= 1'b0;
      dout_s2   <= 1'b0;
      dout_s3   <= 1'b0;
    end else begin
      strobe_s1 <= latch_strobe;
      strobe_s2 <= strobe_s1;
      strobe_s3 <= strobe_s2;
      dout_s1   <= shift_word[synth_config_pkg::SHIFT_W-1];
      dout_s2   <= dout_s1;
      dout_s3   <= dout_s2;
    end
  end

  wire strobe_agree = (strobe_s2 == strobe_s3);
  wire strobe_rise  = strobe_agree & strobe_s2 & ~strobe_stable;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      strobe_stable <= 1'b0;
    end else if (strobe_agree) begin
      strobe_stable <= strobe_s2;
    end
  end

  // data-out level counts only once stages two and three agree
  wire dout_agree = (dout_s2 == dout_s3);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dout_stable <= 1'b0;
    end else if (dout_agree) begin
      dout_stable <= dout_s2;
    end
  end

  // shifter and count are static while the strobe is high, so they are read here as settled words
  // count selects destination
  wire take_cfg  = strobe_rise & (bit_count == synth_config_pkg::CFG_ACCESS_BITS);
  wire take_ref  = strobe_rise & (bit_count == synth_config_pkg::REF_ACCESS_BITS);
  wire take_div  = strobe_rise & (bit_count == synth_config_pkg::DIV_ACCESS_BITS);
  wire take_init = strobe_rise & (bit_count == synth_config_pkg::INIT_GROUP_BITS);

  logic [1:0] init_groups;
  wire  init_fire = take_init & (init_groups == synth_config_pkg::INIT_GROUPS_LAST);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      init_groups <= '0;
    end else if (init_fire) begin
      init_groups <= '0;
    end else if (take_init) begin
      init_groups <= init_groups + 2'h1;
    end else if (strobe_rise) begin
      init_groups <= '0;
    end
  end

  // register file
  synth_config_pkg::config_s cfg;
  logic [12:0]               ref_first;
  logic [12:0]               ref_second;
  logic [2:0]                ref_mode_q;
  logic [23:0]               div_reg;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfg <= synth_config_pkg::CFG_RESET;
    end else if (init_fire) begin
      cfg <= synth_config_pkg::CFG_RESET;
    end else if (take_cfg) begin
      cfg <= shift_word[7:0];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ref_first  <= synth_config_pkg::REF_CNT_RESET;
      ref_mode_q <= synth_config_pkg::REF_MODE_RESET;
    end else if (init_fire) begin
      ref_first  <= synth_config_pkg::REF_CNT_RESET;
      ref_mode_q <= synth_config_pkg::REF_MODE_RESET;
    end else if (take_ref) begin
      ref_first  <= shift_word[synth_config_pkg::REF_CNT_W-1:0];
      ref_mode_q <= shift_word[synth_config_pkg::REF_MODE_HI:synth_config_pkg::REF_MODE_LO];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div_reg    <= synth_config_pkg::DIV_RESET;
      ref_second <= synth_config_pkg::REF_CNT_RESET;
    end else if (init_fire) begin
      div_reg    <= synth_config_pkg::DIV_RESET;
      ref_second <= synth_config_pkg::REF_CNT_RESET;
    end else if (take_div) begin
      div_reg    <= shift_word;
      ref_second <= ref_first;
    end
  end

  // standby and two-step recovery
  power_e power_state;
  power_e next_power_state;

  // pulses ignored until counters run again
  // a pulse in the enable cycle would jam before step one is visible
  wire step_two_go = vco_divided_pulse & counters_run;

  always_comb begin
    next_power_state = power_state;
    unique case (power_state)
      ST_RUN: begin
        if (cfg.low_power_hold) begin
          next_power_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!cfg.low_power_hold) begin
          next_power_state = ST_WAIT_V;
        end
      end
      ST_WAIT_V: begin
        if (cfg.low_power_hold) begin
          next_power_state = ST_HOLD;
        end else if (step_two_go) begin
          next_power_state = ST_RUN;
        end
      end
      default:   next_power_state = ST_HOLD;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      power_state <= ST_RUN;
    end else begin
      power_state <= next_power_state;
    end
  end

  wire in_hold    = (power_state == ST_HOLD);
  wire det_allow  = (power_state == ST_RUN);
  wire jam_now    = (power_state == ST_WAIT_V) & ~cfg.low_power_hold & step_two_go;

  // phase/frequency detector core
  logic pfd_up;
  logic pfd_dn;
  wire  pfd_both = pfd_up & pfd_dn;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pfd_up <= 1'b0;
      pfd_dn <= 1'b0;
    end else if (!det_allow || pfd_both) begin
      pfd_up <= 1'b0;
      pfd_dn <= 1'b0;
    end else begin
      pfd_up <= pfd_up | ref_divided_pulse;
      pfd_dn <= pfd_dn | vco_divided_pulse;
    end
  end

  wire sense_src = cfg.detector_sense_invert ? pfd_dn : pfd_up;
  wire sense_snk = cfg.detector_sense_invert ? pfd_up : pfd_dn;
  wire raw_phi_r = ~sense_src;
  wire raw_phi_v = ~sense_snk;

  wire pd_single_on = cfg.detector_choice & ~cfg.low_power_hold;
  wire pd_pair_on   = ~cfg.detector_choice & ~cfg.low_power_hold;

  wire lock_next = ~cfg.lock_output_allow ? 1'b0 :
                   cfg.low_power_hold     ? 1'b1 :
                   (raw_phi_r & raw_phi_v);

  wire [1:0] outa_sel   = div_reg[synth_config_pkg::OUTA_SEL_HI:synth_config_pkg::OUTA_SEL_LO];
  wire       outa_port  = (outa_sel == synth_config_pkg::OUTA_PORT);
  wire       use_coarse = cfg.port_bit & ~outa_port;
  wire [6:0] pct_next   = synth_config_pkg::pump_pct(cfg.pump_current_select, use_coarse);

  wire outa_next = (outa_sel == synth_config_pkg::OUTA_PORT)      ? cfg.port_bit :
                   (outa_sel == synth_config_pkg::OUTA_REF_PULSE) ? ref_divided_pulse :
                   (outa_sel == synth_config_pkg::OUTA_VCO_PULSE) ? vco_divided_pulse :
                   dout_stable;

  wire ref_isolate = in_hold & (ref_mode_q == synth_config_pkg::REF_STATIC_LOW);

  // output registers, all flops
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      charge_pump_source   <= 1'b0;
      charge_pump_sink     <= 1'b0;
      charge_pump_out_oe_n <= 1'b1;
      phase_r_out          <= 1'b1;
      phase_v_out          <= 1'b1;
      lock_indicator       <= 1'b0;
      pump_current_pct     <= synth_config_pkg::PCT_70;
    end else begin
      charge_pump_source   <= pd_single_on & sense_src;
      charge_pump_sink     <= pd_single_on & sense_snk;
      charge_pump_out_oe_n <= ~pd_single_on;
      phase_r_out          <= pd_pair_on ? raw_phi_r : 1'b1;
      phase_v_out          <= pd_pair_on ? raw_phi_v : 1'b1;
      lock_indicator       <= lock_next;
      pump_current_pct     <= pct_next;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      output_b_out  <= 1'b0;
      output_b_oe_n <= 1'b0;
      output_a      <= 1'b0;
    end else begin
      output_b_out  <= 1'b0;
      output_b_oe_n <= cfg.out_b_release;
      output_a      <= outa_next;
    end
  end

  // counters and bias stop in standby
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ref_feedback_on <= 1'b1;
      ref_input_on    <= 1'b1;
      bias_on         <= 1'b1;
      counters_run    <= 1'b1;
      counter_jam     <= 1'b0;
    end else begin
      ref_feedback_on <= ~ref_isolate;
      ref_input_on    <= ~ref_isolate;
      bias_on         <= ~in_hold;
      counters_run    <= ~in_hold;
      counter_jam     <= jam_now;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      divider_value   <= synth_config_pkg::DIV_RESET;
      ref_count_value <= synth_config_pkg::REF_CNT_RESET;
      ref_mode        <= synth_config_pkg::REF_MODE_RESET;
    end else begin
      divider_value   <= div_reg;
      ref_count_value <= ref_second;
      ref_mode        <= ref_mode_q;
    end
  end

endmodule : synth_config_control
`default_nettype wire

// ### host_serial_model.sv
`default_nettype none
module host_serial_model (
  output var logic serial_clk,
  output var logic serial_data,
  output var logic latch_strobe
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    serial_clk   = 1'b0;
    serial_data  = 1'b0;
    latch_strobe = 1'b1;
  end

  task automatic send(input logic [23:0] w, input int n, input logic init);
    int i;
    latch_strobe = 1'b0;
    #31;
    for (i = n - 1; i >= 0; i--) begin
      serial_data = w[i];
      #62.5 serial_clk = 1'b1;
      if (!(init && i == 0)) #62.5 serial_clk = 1'b0;
    end
    #62.5 latch_strobe = 1'b1;
    // released line: no stale level
    serial_data = ~serial_data;
    #150 serial_clk = 1'b0;
    #250;
  endtask : send
endmodule : host_serial_model
`default_nettype wire

// ### synth_config_chk.sv
`default_nettype none
module synth_config_chk (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        vco_divided_pulse,
  input wire logic        counter_jam,
  input wire logic        counters_run,
  input wire logic        bias_on,
  input wire logic        phase_r_out,
  input wire logic        phase_v_out,
  input wire logic        charge_pump_out_oe_n,
  input wire logic        lock_indicator,
  input wire logic [6:0]  pump_current_pct,
  input wire logic        output_b_out,
  input wire logic        ref_feedback_on,
  input wire logic        ref_input_on,
  input wire logic [2:0]  ref_mode,
  input wire logic [23:0] divider_value,
  input wire logic [12:0] ref_count_value
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence held;
    !counters_run [*3];
  endsequence
  sequence wake;
    $rose(counters_run);
  endsequence

  chk_standby_rest: assert property (
    !counters_run |-> phase_r_out && phase_v_out && charge_pump_out_oe_n)
    else $error("detectors not at rest in standby");
  chk_bias_tracks: assert property (
    bias_on == counters_run) else $error("bias and counters disagree");
  chk_lock_static: assert property (
    held |-> $stable(lock_indicator)) else $error("lock moves in standby");
  chk_ref_cut: assert property (
    held ##0 ref_mode == 3'h0 |-> !ref_feedback_on && !ref_input_on)
    else $error("reference not cut in standby");
  chk_ref_kept: assert property (
    (ref_mode != 3'h0) [*3] |-> ref_feedback_on && ref_input_on)
    else $error("reference cut in other mode");
  chk_wake_blocked: assert property (
    wake |-> !counter_jam && phase_r_out && phase_v_out ##0 ref_feedback_on)
    else $error("detectors free at step one");
  chk_jam_cause: assert property (
    $rose(counter_jam) |-> $past(vco_divided_pulse) && counters_run)
    else $error("jam without vco pulse");
  chk_jam_single: assert property (
    counter_jam |=> !counter_jam) else $error("jam longer than one cycle");
  chk_retain: assert property (
    $fell(counters_run) |-> $stable(divider_value) && $stable(ref_count_value))
    else $error("registers lost at standby");
  chk_pct_legal: assert property (
    pump_current_pct inside {7'h19, 7'h32, 7'h46, 7'h4B, 7'h50, 7'h5A, 7'h64})
    else $error("current step off table");
  chk_outb_low: assert property (
    output_b_out == 1'b0) else $error("output b drives high");
endmodule : synth_config_chk
`default_nettype wire

// ### synth_config_control_tb.sv
`default_nettype none
module synth_config_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {int s; logic [23:0] e;} note_s;
  logic        clk_sys, rst, ref_divided_pulse, vco_divided_pulse;
  logic        serial_clk, serial_data, latch_strobe;
  logic        charge_pump_source, charge_pump_sink, charge_pump_out_oe_n;
  logic        phase_r_out, phase_v_out, lock_indicator, output_a;
  logic        output_b_out, output_b_oe_n, ref_feedback_on, ref_input_on;
  logic        bias_on, counters_run, counter_jam;
  logic [6:0]  pump_current_pct;
  logic [2:0]  ref_mode;
  logic [23:0] divider_value, dv, rw;
  logic        quiet = 1'b1;
  logic [1:0]  poke = 2'h0;
  logic [12:0] ref_count_value;
  logic [16:0] lf = 17'h10828;
  note_s       q[$];
  int          n_fail, num_checks, cycles;
  event        sample_ev;
  string       nm[14] = '{"pct", "oe_n", "phases", "lock", "out_a", "out_b_oe_n",
                          "divider", "ref_count", "ref_mode", "bias", "run", "fb", "ref_in", "pump"};
  logic [6:0]  fine[4] = '{7'h46, 7'h50, 7'h5A, 7'h64};
  logic [6:0]  coarse[4] = '{7'h19, 7'h32, 7'h4B, 7'h64};

  host_serial_model hostm (.serial_clk, .serial_data, .latch_strobe);
  synth_config_control dut (.serial_clk, .serial_data, .latch_strobe, .clk_sys, .rst,
    .ref_divided_pulse, .vco_divided_pulse, .charge_pump_source, .charge_pump_sink,
    .charge_pump_out_oe_n, .pump_current_pct, .phase_r_out, .phase_v_out, .lock_indicator,
    .output_a, .output_b_out, .output_b_oe_n, .ref_feedback_on, .ref_input_on, .ref_mode,
    .bias_on, .counters_run, .counter_jam, .divider_value, .ref_count_value);

  function automatic logic [16:0] lfsr_next(input logic [16:0] v);
    return {v[15:0], v[16] ^ v[13]};
  endfunction : lfsr_next

  function automatic logic [23:0] seen(input int s);
    logic [23:0] r[14];
    r = '{24'(pump_current_pct), 24'(charge_pump_out_oe_n), 24'({phase_r_out, phase_v_out}),
          24'(lock_indicator), 24'(output_a), 24'(output_b_oe_n), divider_value,
          24'(ref_count_value), 24'(ref_mode), 24'(bias_on), 24'(counters_run),
          24'(ref_feedback_on), 24'(ref_input_on), 24'({charge_pump_source, charge_pump_sink})};
    return r[s];
  endfunction : seen

  task automatic expect_val(input int s, input logic [23:0] e);
    q.push_back(note_s'{s, e});
  endtask : expect_val

  task automatic settle;
    repeat (2) @(negedge clk_sys);
    -> sample_ev;
    @(negedge clk_sys);
  endtask : settle

  // one-cycle detector pulse while random pulses are off: bit 0 ref, bit 1 vco
  task automatic pulse(input logic [1:0] p);
    @(posedge clk_sys);
    poke <= p;
    @(posedge clk_sys);
    poke <= 2'h0;
    repeat (2) @(posedge clk_sys);
  endtask : pulse

  task automatic cfg(input logic [7:0] b);
    hostm.send({16'h0000, b}, 8, 1'b0);
  endtask : cfg

  task automatic report_and_stop;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // random detector pulses, vco pulses held off while in reset
  always @(posedge clk_sys) begin
    lf <= lfsr_next(lf);
    ref_divided_pulse <= quiet ? poke[0] : lf[0] & lf[3];
    vco_divided_pulse <= quiet ? poke[1] : lf[1] & lf[5] & !rst;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end

  initial forever begin
    @(sample_ev);
    while (q.size() > 0) begin
      note_s n;
      n = q.pop_front();
      num_checks++;
      if (seen(n.s) !== n.e) begin
        n_fail++;
        $display("ERROR %s expected %0h seen %0h", nm[n.s], n.e, seen(n.s));
      end
    end
  end

  initial begin
    rst = 1'b1;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    expect_val(3, 24'h0);
    expect_val(2, 24'h3);
    expect_val(1, 24'h1);
    settle();
    // polarity swap, pulses held off so detector state is known
    cfg(8'h80);
    expect_val(2, 24'h3);
    settle();
    pulse(2'h1);
    expect_val(2, 24'h2);
    expect_val(13, 24'h0);
    settle();
    cfg(8'hC0);
    expect_val(2, 24'h3);
    expect_val(13, 24'h1);
    settle();
    cfg(8'h40);
    expect_val(13, 24'h2);
    settle();
    cfg(8'h00);
    expect_val(2, 24'h1);
    expect_val(13, 24'h0);
    settle();
    pulse(2'h2);
    expect_val(2, 24'h3);
    settle();
    quiet <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      logic [7:0] b;
      b = {4'h0, k[1:0], k[2], lf[0]};
      cfg(b);
      expect_val(0, 24'(k[2] ? coarse[k % 4] : fine[k % 4]));
      expect_val(5, 24'(b[0]));
      expect_val(6, 24'h0);
      settle();
    end
    cfg(8'h40);
    expect_val(1, 24'h0);
    expect_val(2, 24'h3);
    expect_val(3, 24'h0);
    settle();
    // second buffer moves only on divider load
    rw = {8'h00, 3'h0, 13'(lf)};
    hostm.send(rw, 16, 1'b0);
    expect_val(7, 24'h0);
    settle();
    // ratio fields passed as sent, legality is the host's
    dv = {2'h3, 5'h0A, lf};
    hostm.send(dv, 24, 1'b0);
    expect_val(6, dv);
    expect_val(7, 24'(rw[12:0]));
    expect_val(8, 24'h0);
    settle();
    cfg(8'h26);
    expect_val(4, 24'h1);
    expect_val(0, 24'h50);
    settle();
    // standby with lock allowed, static-low reference
    cfg(8'h36);
    expect_val(9, 24'h0);
    expect_val(10, 24'h0);
    expect_val(3, 24'h1);
    expect_val(4, 24'h1);
    expect_val(6, dv);
    expect_val(11, 24'h0);
    expect_val(12, 24'h0);
    settle();
    cfg(8'h24);
    expect_val(9, 24'h1);
    expect_val(10, 24'h1);
    expect_val(11, 24'h1);
    expect_val(4, 24'h0);
    settle();
    hostm.send(24'h0000FF, 7, 1'b0);
    expect_val(0, 24'h50);
    settle();
    repeat (3) hostm.send(24'h0, 5, 1'b1);
    expect_val(6, 24'h0);
    expect_val(8, 24'h4);
    expect_val(0, 24'h46);
    settle();
    report_and_stop();
  end
endmodule : synth_config_control_tb

bind synth_config_control synth_config_chk chk (.clk_sys, .rst, .vco_divided_pulse, .counter_jam,
  .counters_run, .bias_on, .phase_r_out, .phase_v_out, .charge_pump_out_oe_n, .lock_indicator,
  .pump_current_pct, .output_b_out, .ref_feedback_on, .ref_input_on, .ref_mode, .divider_value,
  .ref_count_value);
`default_nettype wire
